/* File: src/ebc_pkg.sv */
// constants and types for the external bus control block
package ebc_pkg;
  // bus widths
  localparam int unsigned ADDR_W     = 23;
  localparam int unsigned ADDR_LO_W  = 16;
  localparam int unsigned ADDR_HI_W  = ADDR_W - ADDR_LO_W;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned WS_W       = 3;

  // external space codes
  localparam logic [1:0] SPACE_DATA  = 2'h0;
  localparam logic [1:0] SPACE_PROG  = 2'h1;
  localparam logic [1:0] SPACE_IO    = 2'h2;

  // wait state figures
  localparam logic [WS_W-1:0] WS_NONE      = 3'h0;
  localparam logic [WS_W-1:0] WS_LAST      = 3'h1;
  localparam logic [WS_W-1:0] WS_READY_MIN = 3'h2;

  // reset and idle levels
  localparam logic               PIN_HIGH   = 1'b1;
  localparam logic               PIN_LOW    = 1'b0;
  localparam logic [ADDR_W-1:0]  ADDR_RST   = 23'h00_0000;
  localparam logic [DATA_W-1:0]  DATA_RST   = 16'h0000;

  typedef enum logic [2:0] {
    EBC_IDLE  = 3'h0,
    EBC_ACC   = 3'h1,
    EBC_SWAIT = 3'h3,
    EBC_RDY   = 3'h2,
    EBC_HOLD  = 3'h4
  } ebc_state_t;
endpackage : ebc_pkg

/* File: src/ebc_wait_if.sv */
// carrier between the bus controller and its wait state counter
`timescale 1ns/1ps
`default_nettype none
interface ebc_wait_if;
  import ebc_pkg::*;
  logic            load;
  logic [WS_W-1:0] load_val;
  logic            dec;
  logic [WS_W-1:0] cnt;
  logic [WS_W-1:0] cnt_next;
  modport ctrl    (output load, output load_val, output dec, input cnt, input cnt_next);
  modport counter (input load, input load_val, input dec, output cnt, output cnt_next);
endinterface : ebc_wait_if
`default_nettype wire

/* File: src/ebc_wait_counter.sv */
// software wait state down counter
`timescale 1ns/1ps
`default_nettype none
module ebc_wait_counter
  import ebc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  // controller side
  ebc_wait_if.counter wif
);
  always_comb begin
    if (wif.load) begin
      wif.cnt_next = wif.load_val;
    end else if (wif.dec && (wif.cnt != WS_NONE)) begin
      wif.cnt_next = wif.cnt - WS_LAST;
    end else begin
      wif.cnt_next = wif.cnt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wif.cnt <= WS_NONE;
    end else begin
      wif.cnt <= wif.cnt_next;
    end
  end
endmodule : ebc_wait_counter
`default_nettype wire

/* File: src/ebc_bus_ctrl.sv */
// external parallel bus control: space selects, strobes, waits and hold
`timescale 1ns/1ps
`default_nettype none
// Operation
// - space selects idle high; only the accessed space goes low while address valid.
// - space selects float during hold or while output float is low.
// - memory strobe low only for external data or program accesses.
// - I/O strobe low only for external I/O accesses.
// - direction high meaning read; low only during an external write.
// - strobes and direction float during hold or while output float is low.
// - ready low means wait one more cycle and sample again.
// - ready sampled only with two or more wait states, after they finish.
// - a bus release request, once granted, floats address, data and control.
// - grant asserted only while in hold with the bus floated.
// - grant output floats while output float is low.
// - low sixteen address lines driven except in hold or while output float is low; upper seven only for program space.
// - data floats unless writing, in reset, on release request, or float.
// - wait-complete low from first wait state, high from start of last.
module ebc_bus_ctrl
  import ebc_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 srst_i,
  // cpu request side
  input  wire logic                 req_i,
  input  wire logic [1:0]           space_i,
  input  wire logic                 write_i,
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  input  wire logic [WS_W-1:0]      wait_states_i,
  output logic                      done_o,
  output logic [DATA_W-1:0]         rdata_o,
  // external control inputs
  input  wire logic                 ready_i,
  input  wire logic                 bus_release_req_n_i,
  input  wire logic                 output_float_n_i,
  // address and data pins
  output logic [ADDR_W-1:0]         addr_o,
  output logic                      addr_lo_oe_o,
  output logic                      addr_hi_oe_o,
  input  wire logic [DATA_W-1:0]    data_i,
  output logic [DATA_W-1:0]         data_o,
  output logic                      data_oe_o,
  // space selects
  output logic                      data_space_select_n_o,
  output logic                      program_space_select_n_o,
  output logic                      io_space_select_n_o,
  output logic                      select_oe_o,
  // strobes and direction
  output logic                      memory_strobe_n_o,
  output logic                      io_strobe_n_o,
  output logic                      read_write_n_o,
  output logic                      strobe_oe_o,
  // wait complete and bus grant
  output logic                      wait_complete_n_o,
  output logic                      wait_complete_oe_o,
  output logic                      bus_release_grant_n_o,
  output logic                      bus_release_grant_oe_o
);
  ebc_state_t          state_reg;
  ebc_state_t          state_next;
  logic [1:0]          space_reg;
  logic                write_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic [WS_W-1:0]     ws_reg;
  logic                accept;
  logic                in_access_next;
  logic                finish;
  logic                ws_ready;

  ebc_wait_if wif ();

  ebc_wait_counter ebc_wait_counter_inst (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .wif       (wif.counter)
  );

  assign ws_ready = (ws_reg >= WS_READY_MIN);
  assign accept   = (state_reg == EBC_IDLE) && bus_release_req_n_i && req_i;

  // next state
  always_comb begin
    state_next   = state_reg;
    wif.load     = 1'b0;
    wif.load_val = ws_reg;
    wif.dec      = 1'b0;
    case (state_reg)
      EBC_IDLE: begin
        if (!bus_release_req_n_i) begin
          state_next = EBC_HOLD;
        end else if (req_i) begin
          state_next = EBC_ACC;
        end
      end
      EBC_ACC: begin
        if (ws_reg == WS_NONE) begin
          state_next = EBC_IDLE;
        end else begin
          wif.load   = 1'b1;
          state_next = EBC_SWAIT;
        end
      end
      EBC_SWAIT: begin
        wif.dec = 1'b1;
        if (wif.cnt == WS_LAST) begin
          state_next = ws_ready ? EBC_RDY : EBC_IDLE;
        end
      end
      EBC_RDY: begin
        if (ready_i) begin
          state_next = EBC_IDLE;
        end
      end
      EBC_HOLD: begin
        if (bus_release_req_n_i) begin
          state_next = EBC_IDLE;
        end
      end
      default: begin
        state_next = EBC_IDLE;
      end
    endcase
  end

  assign in_access_next = (state_next == EBC_ACC) || (state_next == EBC_SWAIT)
                          || (state_next == EBC_RDY);
  assign finish = (state_reg != EBC_IDLE) && (state_reg != EBC_HOLD)
                  && (state_next == EBC_IDLE);

  // state
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg <= EBC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request capture
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      space_reg <= SPACE_DATA;
      write_reg <= PIN_LOW;
      addr_reg  <= ADDR_RST;
      wdata_reg <= DATA_RST;
      ws_reg    <= WS_NONE;
    end else if (accept) begin
      space_reg <= space_i;
      write_reg <= write_i;
      addr_reg  <= addr_i;
      wdata_reg <= wdata_i;
      ws_reg    <= wait_states_i;
    end
  end

  // cpu answer
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      done_o  <= PIN_LOW;
      rdata_o <= DATA_RST;
    end else begin
      done_o <= finish;
      if (finish && !write_reg) begin
        rdata_o <= data_i;
      end
    end
  end

  // address and data pins
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr_o       <= ADDR_RST;
      addr_lo_oe_o <= PIN_LOW;
      addr_hi_oe_o <= PIN_LOW;
      data_o       <= DATA_RST;
      data_oe_o    <= PIN_LOW;
    end else begin
      addr_o       <= accept ? addr_i : addr_reg;
      addr_lo_oe_o <= output_float_n_i && (state_next != EBC_HOLD);
      addr_hi_oe_o <= output_float_n_i && in_access_next
                      && ((accept ? space_i : space_reg) == SPACE_PROG);
      data_o       <= accept ? wdata_i : wdata_reg;
      data_oe_o    <= output_float_n_i && bus_release_req_n_i && in_access_next
                      && (accept ? write_i : write_reg);
    end
  end

  // space selects, strobes and direction
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      data_space_select_n_o    <= PIN_HIGH;
      program_space_select_n_o <= PIN_HIGH;
      io_space_select_n_o      <= PIN_HIGH;
      memory_strobe_n_o        <= PIN_HIGH;
      io_strobe_n_o            <= PIN_HIGH;
      read_write_n_o           <= PIN_HIGH;
      select_oe_o              <= PIN_LOW;
      strobe_oe_o              <= PIN_LOW;
    end else begin
      data_space_select_n_o    <= !(in_access_next
                                    && ((accept ? space_i : space_reg) == SPACE_DATA));
      program_space_select_n_o <= !(in_access_next
                                    && ((accept ? space_i : space_reg) == SPACE_PROG));
      io_space_select_n_o      <= !(in_access_next
                                    && ((accept ? space_i : space_reg) == SPACE_IO));
      memory_strobe_n_o        <= !(in_access_next
                                    && ((accept ? space_i : space_reg) != SPACE_IO));
      io_strobe_n_o            <= !(in_access_next
                                    && ((accept ? space_i : space_reg) == SPACE_IO));
      read_write_n_o           <= !(in_access_next && (accept ? write_i : write_reg));
      select_oe_o              <= output_float_n_i && (state_next != EBC_HOLD);
      strobe_oe_o              <= output_float_n_i && (state_next != EBC_HOLD);
    end
  end

  // wait complete and bus grant
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wait_complete_n_o      <= PIN_HIGH;
      wait_complete_oe_o     <= PIN_LOW;
      bus_release_grant_n_o  <= PIN_HIGH;
      bus_release_grant_oe_o <= PIN_LOW;
    end else begin
      wait_complete_n_o      <= !((state_next == EBC_SWAIT) && ws_ready
                                  && (wif.cnt_next > WS_LAST));
      wait_complete_oe_o     <= output_float_n_i;
      bus_release_grant_n_o  <= !(state_next == EBC_HOLD);
      bus_release_grant_oe_o <= output_float_n_i;
    end
  end
endmodule : ebc_bus_ctrl
`default_nettype wire

/* File: tb/ebc_ext_dev.sv */
// far-side memory and io device model with programmable ready delay
`timescale 1ns/1ps
`default_nettype none
module ebc_ext_dev
  import ebc_pkg::*;
(
  // bus side
  input  wire logic              ref_clk_i,
  input  wire logic              strobe_n_i,
  input  wire logic              read_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // bench side
  input  wire logic [3:0]        stall_i,
  output logic                   ready_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [DATA_W-1:0]      wr_seen_o
);
  logic [3:0]        cnt_reg;
  logic [DATA_W-1:0] last_reg;
  always_ff @(posedge ref_clk_i) begin
    cnt_reg <= strobe_n_i ? 4'h0 : cnt_reg + 4'h1;
    last_reg <= rdata_o;
    if (!strobe_n_i && !read_i) wr_seen_o <= wdata_i;
  end
  // ready only after stall cycles of strobe
  assign ready_o = !strobe_n_i && (cnt_reg >= stall_i);
  // released bus toggles so stale data cannot pass
  assign rdata_o = (!strobe_n_i && read_i) ? ~addr_i[15:0] : ~last_reg;
endmodule : ebc_ext_dev
`default_nettype wire

/* File: tb/ebc_bus_ctrl_chk.sv */
// concurrent checks on the external bus control pins
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_ctrl_chk
  import ebc_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            srst_i,
  // request side
  input  wire logic            write_i,
  input  wire logic [WS_W-1:0] wait_states_i,
  input  wire logic            done_o,
  // external control inputs
  input  wire logic            ready_i,
  input  wire logic            bus_release_req_n_i,
  input  wire logic            output_float_n_i,
  // pin enables
  input  wire logic            addr_lo_oe_o,
  input  wire logic            addr_hi_oe_o,
  input  wire logic            data_oe_o,
  input  wire logic            select_oe_o,
  input  wire logic            strobe_oe_o,
  input  wire logic            wait_complete_oe_o,
  input  wire logic            bus_release_grant_oe_o,
  // selects, strobes and direction
  input  wire logic            data_space_select_n_o,
  input  wire logic            program_space_select_n_o,
  input  wire logic            io_space_select_n_o,
  input  wire logic            memory_strobe_n_o,
  input  wire logic            io_strobe_n_o,
  input  wire logic            read_write_n_o,
  // wait complete and grant
  input  wire logic            wait_complete_n_o,
  input  wire logic            bus_release_grant_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence acc_start;
    $fell(memory_strobe_n_o & io_strobe_n_o);
  endsequence
  chk_sel_one_low: assert property (
    $countones({data_space_select_n_o, program_space_select_n_o, io_space_select_n_o}) >= 2)
    else $error("two space selects low");
  chk_mem_strobe: assert property (!memory_strobe_n_o |-> io_strobe_n_o &&
    io_space_select_n_o && !(data_space_select_n_o && program_space_select_n_o))
    else $error("memory strobe without memory select");
  chk_io_strobe: assert property (
    !io_strobe_n_o |-> !io_space_select_n_o && memory_strobe_n_o)
    else $error("io strobe without io select");
  chk_dir_write: assert property (
    !read_write_n_o |-> write_i && !(memory_strobe_n_o && io_strobe_n_o))
    else $error("direction low outside a write");
  chk_float_oe: assert property (!output_float_n_i |=>
    !select_oe_o && !strobe_oe_o && !bus_release_grant_oe_o && !addr_lo_oe_o
    && !addr_hi_oe_o && !data_oe_o && !wait_complete_oe_o)
    else $error("pins driven while output float low");
  chk_grant_float: assert property (!bus_release_grant_n_o |->
    !select_oe_o && !strobe_oe_o && !addr_lo_oe_o && !data_oe_o && !$past(bus_release_req_n_i))
    else $error("grant without floated bus");
  chk_ws_zero: assert property (
    acc_start and wait_states_i == WS_NONE |=> done_o)
    else $error("zero wait access late");
  chk_msc_pulse: assert property (
    acc_start and wait_states_i == WS_READY_MIN |=> !wait_complete_n_o ##1 wait_complete_n_o)
    else $error("wait complete pulse wrong");
  chk_ready_done: assert property (
    done_o && wait_states_i >= WS_READY_MIN |-> $past(ready_i))
    else $error("finished without ready");
  chk_addr_hi_prog: assert property (
    addr_hi_oe_o == (!program_space_select_n_o && select_oe_o))
    else $error("upper address enable outside program access");
  chk_release_data: assert property (
    !bus_release_req_n_i |=> !data_oe_o)
    else $error("data driven after release request");
endmodule : ebc_bus_ctrl_chk
bind ebc_bus_ctrl ebc_bus_ctrl_chk ebc_bus_ctrl_chk_inst (
  .ref_clk_i                (ref_clk_i),
  .srst_i                   (srst_i),
  .write_i                  (write_i),
  .wait_states_i            (wait_states_i),
  .done_o                   (done_o),
  .ready_i                  (ready_i),
  .bus_release_req_n_i      (bus_release_req_n_i),
  .output_float_n_i         (output_float_n_i),
  .addr_lo_oe_o             (addr_lo_oe_o),
  .addr_hi_oe_o             (addr_hi_oe_o),
  .data_oe_o                (data_oe_o),
  .select_oe_o              (select_oe_o),
  .strobe_oe_o              (strobe_oe_o),
  .wait_complete_oe_o       (wait_complete_oe_o),
  .bus_release_grant_oe_o   (bus_release_grant_oe_o),
  .data_space_select_n_o    (data_space_select_n_o),
  .program_space_select_n_o (program_space_select_n_o),
  .io_space_select_n_o      (io_space_select_n_o),
  .memory_strobe_n_o        (memory_strobe_n_o),
  .io_strobe_n_o            (io_strobe_n_o),
  .read_write_n_o           (read_write_n_o),
  .wait_complete_n_o        (wait_complete_n_o),
  .bus_release_grant_n_o    (bus_release_grant_n_o)
);
`default_nettype wire

/* File: tb/ebc_bus_ctrl_tb.sv */
// self-checking bench for the external bus control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ebc_bus_ctrl_tb;
  import ebc_pkg::*;
  logic              ref_clk_i = 0, srst_i = 1, req_i = 0, write_i = 0, rel_n = 1, flt_n = 1;
  logic [1:0]        space_i = 0;
  logic [ADDR_W-1:0] addr_i = 0, addr_o;
  logic [DATA_W-1:0] wdata_i = 0, rdata_o, data_o, ext_d, wr_seen, bus;
  logic [WS_W-1:0]   ws = 0;
  logic [3:0]        stall = 0;
  logic              rdy, done_o, data_oe, sel_oe, stb_oe, mstb_n, iostb_n, rw_n, gnt_n, gnt_oe;
  int                fails = 0, comparisons = 0;
  assign bus = data_oe ? data_o : ext_d;
  initial forever #25 ref_clk_i = ~ref_clk_i;
  ebc_bus_ctrl ebc_bus_ctrl_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req_i),
    .space_i(space_i), .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i), .wait_states_i(ws),
    .done_o(done_o), .rdata_o(rdata_o), .ready_i(rdy), .bus_release_req_n_i(rel_n),
    .output_float_n_i(flt_n), .addr_o(addr_o), .addr_lo_oe_o(), .addr_hi_oe_o(), .data_i(bus),
    .data_o(data_o), .data_oe_o(data_oe), .data_space_select_n_o(), .program_space_select_n_o(),
    .io_space_select_n_o(), .select_oe_o(sel_oe), .memory_strobe_n_o(mstb_n),
    .io_strobe_n_o(iostb_n), .read_write_n_o(rw_n), .strobe_oe_o(stb_oe), .wait_complete_n_o(),
    .wait_complete_oe_o(), .bus_release_grant_n_o(gnt_n), .bus_release_grant_oe_o(gnt_oe));
  ebc_ext_dev ebc_ext_dev_inst (.ref_clk_i(ref_clk_i), .strobe_n_i(mstb_n & iostb_n),
    .read_i(rw_n), .addr_i(addr_o), .wdata_i(bus), .stall_i(stall), .ready_o(rdy),
    .rdata_o(ext_d), .wr_seen_o(wr_seen));
  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      end_sim();
    end
  endtask : wait_done
  task automatic access(input logic [1:0] sp, input logic wr, input logic [WS_W-1:0] w,
                        input logic [3:0] st, input int exp_n);
    int n;
    @(negedge ref_clk_i);
    space_i = sp;
    write_i = wr;
    ws = w;
    stall = st;
    addr_i = {3'h5, sp, w, 15'h1234};
    wdata_i = {w, sp, 11'h3c5};
    req_i = 1;
    wait_done(n);
    req_i = 0;
    `CHK(n, exp_n)
    if (wr) `CHK(wr_seen, wdata_i)
    else `CHK(rdata_o, ~addr_i[15:0])
  endtask : access
  task automatic t_spaces;
    for (int s = 0; s < 3; s++) access(s[1:0], 1'b0, WS_NONE, 4'h0, 2);
    access(SPACE_IO, 1'b1, WS_NONE, 4'h0, 2);
    $display("t_spaces done");
  endtask : t_spaces
  task automatic t_waits;
    access(SPACE_DATA, 1'b1, WS_LAST, 4'hf, 3);
    access(SPACE_PROG, 1'b1, 3'h2, 4'h3, 5);
    access(SPACE_IO, 1'b0, 3'h3, 4'h6, 8);
    access(SPACE_PROG, 1'b0, 3'h7, 4'h8, 10);
    $display("t_waits done");
  endtask : t_waits
  task automatic t_hold;
    int n;
    @(negedge ref_clk_i);
    rel_n = 0;
    ws = WS_NONE;
    req_i = 1;
    repeat (3) @(negedge ref_clk_i);
    `CHK(gnt_n, 1'b0)
    `CHK(sel_oe, 1'b0)
    `CHK(stb_oe, 1'b0)
    `CHK(data_oe, 1'b0)
    `CHK(done_o, 1'b0)
    rel_n = 1;
    wait_done(n);
    req_i = 0;
    `CHK(n, 3)
    `CHK(gnt_n, 1'b1)
    $display("t_hold done");
  endtask : t_hold
  task automatic t_hold_busy;
    int n;
    @(negedge ref_clk_i);
    space_i = SPACE_DATA;
    write_i = 1'b1;
    ws = 3'h3;
    stall = 4'h0;
    req_i = 1;
    repeat (2) @(negedge ref_clk_i);
    rel_n = 0;
    @(negedge ref_clk_i);
    `CHK(data_oe, 1'b0)
    `CHK(mstb_n, 1'b0)
    `CHK(gnt_n, 1'b1)
    wait_done(n);
    req_i = 0;
    `CHK(n, 3)
    @(negedge ref_clk_i);
    `CHK(gnt_n, 1'b0)
    `CHK(stb_oe, 1'b0)
    rel_n = 1;
    @(negedge ref_clk_i);
    `CHK(gnt_n, 1'b1)
    $display("t_hold_busy done");
  endtask : t_hold_busy
  task automatic t_float;
    @(negedge ref_clk_i);
    flt_n = 0;
    repeat (2) @(negedge ref_clk_i);
    `CHK({sel_oe, stb_oe}, 2'h0)
    `CHK(gnt_oe, 1'b0)
    flt_n = 1;
    repeat (2) @(negedge ref_clk_i);
    `CHK({sel_oe, gnt_oe}, 2'h3)
    $display("t_float done");
  endtask : t_float
  initial begin
    repeat (8) @(negedge ref_clk_i);
    srst_i = 0;
    t_spaces();
    t_waits();
    t_hold();
    t_hold_busy();
    t_float();
    end_sim();
  end
endmodule : ebc_bus_ctrl_tb
`default_nettype wire
